// ---- src/pal_line_port.sv ----
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Both pulse requests are sampled on each rising transmit clock edge.
// - A sampled positive request alone sends one positive mark for that bit.
// - A sampled negative request alone sends one negative mark for that bit; both high send a space.
// - Positive receive indication asserts when a positive line pulse is seen.
// - Negative receive indication asserts when a negative line pulse is seen.
// - A receive clock recovered from line pulses accompanies the indications.
// - Both directions run up to 2.048 Mbps; transmit clock must not exceed it.
// - A request is active at logic high; high positive alone gives positive pulse.
// - On loss of line signal, receive data and clock outputs are forced high.
module pal_line_port (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic tx_bit_clock,
  input  wire logic tx_positive_pulse_req,
  input  wire logic tx_negative_pulse_req,
  output logic      line_drive_p,
  output logic      line_drive_n,
  input  wire logic line_sense_p,
  input  wire logic line_sense_n,
  output logic      rx_positive_pulse_ind,
  output logic      rx_negative_pulse_ind,
  output logic      rx_recovered_clock,
  output logic      rx_signal_lost,
  output logic      tx_rate_error
);
  import pal_pkg::*;

  // Three-stage sampling of every pin; first stages feed only the second
  logic [2:0] tck_s_q, tp_s_q, tn_s_q, lp_s_q, ln_s_q;
  logic       tck_prev_q, lp_hold_q, ln_hold_q;

  // A level moves only once the last two stages agree, so a lone glitch is ignored
  function automatic logic settled(input logic [2:0] s, input logic held);
    settled = (s[1] == s[2]) ? s[2] : held;
  endfunction

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tck_s_q    <= 3'h0;
      tp_s_q     <= 3'h0;
      tn_s_q     <= 3'h0;
      lp_s_q     <= 3'h0;
      ln_s_q     <= 3'h0;
      tck_prev_q <= 1'b0;
      lp_hold_q  <= 1'b0;
      ln_hold_q  <= 1'b0;
    end else begin
      tck_s_q    <= {tck_s_q[1:0], tx_bit_clock};
      tp_s_q     <= {tp_s_q[1:0], tx_positive_pulse_req};
      tn_s_q     <= {tn_s_q[1:0], tx_negative_pulse_req};
      lp_s_q     <= {lp_s_q[1:0], line_sense_p};
      ln_s_q     <= {ln_s_q[1:0], line_sense_n};
      tck_prev_q <= settled(tck_s_q, tck_prev_q);
      lp_hold_q  <= settled(lp_s_q, lp_hold_q);
      ln_hold_q  <= settled(ln_s_q, ln_hold_q);
    end
  end

  logic tck_rise;
  logic tp_lvl, tn_lvl, lp_lvl, ln_lvl;
  assign tck_rise = settled(tck_s_q, tck_prev_q) && !tck_prev_q;
  // Requests are held around the edge, so the stable stage is safe to take
  assign tp_lvl   = tp_s_q[2];
  assign tn_lvl   = tn_s_q[2];
  assign lp_lvl   = settled(lp_s_q, lp_hold_q);
  assign ln_lvl   = settled(ln_s_q, ln_hold_q);

  // Sampled request pair enters the buffer on each rising transmit clock edge while the buffer has room
  logic             buf_in_ready, buf_out_valid, buf_pop;
  logic [DATA_W-1:0] buf_out_data;

  pal_buf2 u_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (tck_rise),
    .in_ready  (buf_in_ready),
    .in_data   ({tp_lvl, tn_lvl}),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // Transmit mark shaping
  pal_tx_state_e tx_st_q, tx_st_d;
  logic [7:0]    tx_cnt_q, tx_cnt_d;
  logic [1:0]    tx_sym_q, tx_sym_d;
  logic [7:0]    bit_len_q, bit_len_d;
  logic          rate_err_q, rate_err_d;

  always_comb begin
    tx_st_d    = tx_st_q;
    tx_cnt_d   = tx_cnt_q;
    tx_sym_d   = tx_sym_q;
    bit_len_d  = bit_len_q;
    rate_err_d = rate_err_q;
    buf_pop    = 1'b0;
    if (tck_rise) begin
      bit_len_d = 8'h0;
      // rate ceiling check
      // Edge spacing is bit_len_q + 1; sampling jitter shortens a legal gap to the floor
      if (bit_len_q < 8'(MIN_BIT_CYCLES - 1)) begin
        rate_err_d = 1'b1;
      end
      if (!buf_in_ready) begin
        rate_err_d = 1'b1;
      end
    end else if (bit_len_q != 8'hff) begin
      bit_len_d = bit_len_q + 8'h1;
    end
    unique case (tx_st_q)
      PAL_TX_IDLE: begin
        if (buf_out_valid) begin
          buf_pop  = 1'b1;
          tx_sym_d = buf_out_data;
          tx_cnt_d = 8'h0;
          tx_st_d  = PAL_TX_MARK;
        end
      end
      PAL_TX_MARK: begin
        tx_cnt_d = tx_cnt_q + 8'h1;
        if (tx_cnt_q == 8'(TX_PULSE_CYCLES - 1)) begin
          tx_sym_d = 2'h0;
          tx_st_d  = PAL_TX_HOLD;
        end
      end
      PAL_TX_HOLD: begin
        // Popping here gives four cycles a symbol, faster than the top rate
        if (buf_out_valid) begin
          buf_pop  = 1'b1;
          tx_sym_d = buf_out_data;
          tx_cnt_d = 8'h0;
          tx_st_d  = PAL_TX_MARK;
        end else begin
          tx_st_d = PAL_TX_IDLE;
        end
      end
      default: begin
        tx_st_d = PAL_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q    <= PAL_TX_IDLE;
      tx_cnt_q   <= 8'h0;
      tx_sym_q   <= 2'h0;
      bit_len_q  <= 8'hff;
      rate_err_q <= 1'b0;
    end else begin
      tx_st_q    <= tx_st_d;
      tx_cnt_q   <= tx_cnt_d;
      tx_sym_q   <= tx_sym_d;
      bit_len_q  <= bit_len_d;
      rate_err_q <= rate_err_d;
    end
  end

  assign line_drive_p  = tx_sym_q[1] && !tx_sym_q[0];
  // negative mark; both set is illegal and sends a space
  assign line_drive_n  = tx_sym_q[0] && !tx_sym_q[1];
  assign tx_rate_error = rate_err_q;

  // Receive side
  logic       rp_q, rp_d, rn_q, rn_d, rck_q, rck_d, lost_q, lost_d;
  logic [7:0] rck_cnt_q, rck_cnt_d, los_cnt_q, los_cnt_d;

  always_comb begin
    rp_d      = lp_lvl && !ln_lvl;
    rn_d      = ln_lvl && !lp_lvl;
    rck_d     = rck_q;
    rck_cnt_d = rck_cnt_q;
    los_cnt_d = los_cnt_q;
    lost_d    = lost_q;
    if (lp_lvl || ln_lvl) begin
      rck_d     = 1'b1;
      rck_cnt_d = 8'h0;
    end else if (rck_cnt_q != 8'(RX_HALF_CYCLES)) begin
      rck_cnt_d = rck_cnt_q + 8'h1;
    end else begin
      rck_d = 1'b0;
    end
    if (lp_lvl || ln_lvl) begin
      los_cnt_d = 8'h0;
      lost_d    = 1'b0;
    end else if (los_cnt_q == 8'(LOS_CYCLES - 1)) begin
      lost_d = 1'b1;
    end else begin
      los_cnt_d = los_cnt_q + 8'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rp_q      <= 1'b0;
      rn_q      <= 1'b0;
      rck_q     <= 1'b0;
      rck_cnt_q <= 8'h0;
      los_cnt_q <= 8'h0;
      lost_q    <= 1'b0;
    end else begin
      rp_q      <= rp_d;
      rn_q      <= rn_d;
      rck_q     <= rck_d;
      rck_cnt_q <= rck_cnt_d;
      los_cnt_q <= los_cnt_d;
      lost_q    <= lost_d;
    end
  end

  assign rx_positive_pulse_ind = rp_q || lost_q;
  assign rx_negative_pulse_ind = rn_q || lost_q;
  assign rx_recovered_clock    = rck_q || lost_q;
  assign rx_signal_lost        = lost_q;
endmodule
`default_nettype wire

// ---- src/pal_pkg.sv ----
package pal_pkg;
  // Bit rate ceiling and rates
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned MAX_BIT_RATE_BPS = 2_048_000;
  // Shortest legal bit period in cycles, rounded down
  localparam int unsigned MIN_BIT_CYCLES   = CLK_HZ / MAX_BIT_RATE_BPS;
  // Transmit mark width at the top rate, 244 ns typical
  localparam int unsigned TX_PULSE_NS      = 244;
  localparam int unsigned TX_PULSE_CYCLES  =
    ((TX_PULSE_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
  // Line silence before loss-of-signal, in bit periods
  localparam int unsigned LOS_BIT_PERIODS  = 32;
  localparam int unsigned LOS_CYCLES       = LOS_BIT_PERIODS * 5;
  // Receive clock half period used while regenerating
  localparam int unsigned RX_HALF_CYCLES   = 2;
  localparam int unsigned BUF_DEPTH        = 2;
  localparam int unsigned DATA_W           = 2;
  localparam logic [1:0]  SYNC_RESET       = 2'h0;

  typedef enum logic [2:0] {
    PAL_TX_IDLE = 3'b001,
    PAL_TX_MARK = 3'b010,
    PAL_TX_HOLD = 3'b100
  } pal_tx_state_e;
endpackage

// ---- src/pal_buf2.sv ----
`timescale 1ns/100ps
`default_nettype none
module pal_buf2 (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [pal_pkg::DATA_W-1:0] in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic      [pal_pkg::DATA_W-1:0] out_data
);
  import pal_pkg::*;
  logic [DATA_W-1:0] mem_q [BUF_DEPTH];
  logic [DATA_W-1:0] mem_d [BUF_DEPTH];
  logic              wr_q, wr_d, rd_q, rd_d;
  logic [1:0]        cnt_q, cnt_d;
  logic              push, pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_q[0] <= 2'h0;
      mem_q[1] <= 2'h0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ---- verif/pal_line_port_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module pal_line_port_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tx_bit_clock,
  input wire logic tx_positive_pulse_req,
  input wire logic tx_negative_pulse_req,
  input wire logic line_drive_p,
  input wire logic line_drive_n,
  input wire logic line_sense_p,
  input wire logic line_sense_n,
  input wire logic rx_positive_pulse_ind,
  input wire logic rx_negative_pulse_ind,
  input wire logic rx_recovered_clock,
  input wire logic rx_signal_lost
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence mark_s(sig);
    sig[*3] ##1 !sig;
  endsequence
  // Five cycles covers three sync stages and the output register
  sequence held_s(lvl);
    lvl[*5];
  endsequence
  pos_mark_a: assert property ($rose(line_drive_p) |-> mark_s(line_drive_p))
    else $error("positive mark width");
  neg_mark_a: assert property ($rose(line_drive_n) |-> mark_s(line_drive_n))
    else $error("negative mark width");
  pos_request_a: assert property ($rose(tx_bit_clock) && tx_positive_pulse_req
    && !tx_negative_pulse_req |-> ##[2:9] $rose(line_drive_p)) else $error("no positive mark");
  neg_request_a: assert property ($rose(tx_bit_clock) && tx_negative_pulse_req
    && !tx_positive_pulse_req |-> ##[2:9] $rose(line_drive_n)) else $error("no negative mark");
  pos_sense_a: assert property (held_s(line_sense_p && !line_sense_n)
    |-> rx_positive_pulse_ind) else $error("positive pulse missed");
  neg_sense_a: assert property (held_s(line_sense_n && !line_sense_p)
    |-> rx_negative_pulse_ind) else $error("negative pulse missed");
  rx_clock_a: assert property (rx_positive_pulse_ind || rx_negative_pulse_ind
    |-> rx_recovered_clock) else $error("no receive clock");
  loss_force_a: assert property (rx_signal_lost[*2]
    |-> rx_positive_pulse_ind && rx_negative_pulse_ind && rx_recovered_clock)
    else $error("loss not forced");
  loss_clear_a: assert property (held_s(line_sense_p || line_sense_n)
    |-> !rx_signal_lost) else $error("loss not cleared by mark");
endmodule
bind pal_line_port pal_line_port_assertions pal_line_port_assertions_inst (.*);
`default_nettype wire

// ---- verif/pal_term_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pal_term_model (
  input  wire logic       send,
  input  wire logic       fast,
  input  wire logic [7:0] pos_bits,
  input  wire logic [7:0] neg_bits,
  output logic            tx_bit_clock,
  output logic            tx_positive_pulse_req,
  output logic            tx_negative_pulse_req,
  output logic            busy
);
  initial begin
    tx_bit_clock = 1'b0;
    tx_positive_pulse_req = 1'b0;
    tx_negative_pulse_req = 1'b0;
    busy = 1'b0;
  end
  // Bit clock runs only inside a frame, phase unrelated to the system clock
  always @(posedge send) begin
    #37 busy = 1'b1;
    for (int i = 0; i < 8; i++) begin
      // requests change only while the clock is low
      tx_positive_pulse_req = pos_bits[i];
      tx_negative_pulse_req = neg_bits[i];
      // period 800 ns, or 488 ns at the top rate
      #(fast ? 244 : 400) tx_bit_clock = 1'b1;
      #(fast ? 244 : 400) tx_bit_clock = 1'b0;
    end
    tx_positive_pulse_req = 1'b0;
    tx_negative_pulse_req = 1'b0;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// ---- verif/tb_pal_line_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_pal_line_port;
  import pal_pkg::*;
  logic       clk_sys = 1'b0, arst_n = 1'b0, send = 1'b0, fast = 1'b0;
  logic       line_sense_p = 1'b0, line_sense_n = 1'b0;
  logic [7:0] pos_bits = 8'h00, neg_bits = 8'h00;
  logic       tx_bit_clock, tx_positive_pulse_req, tx_negative_pulse_req, busy;
  logic       line_drive_p, line_drive_n, rx_positive_pulse_ind, rx_negative_pulse_ind;
  logic       rx_recovered_clock, rx_signal_lost, tx_rate_error;
  int         errors = 0, n_tests = 0, cycles = 0, p_cnt = 0, n_cnt = 0;
  wire logic [3:0] rx_bus = {rx_positive_pulse_ind, rx_negative_pulse_ind,
                             rx_recovered_clock, rx_signal_lost};
  pal_line_port pal_line_port_inst (.*);
  pal_term_model pal_term_model_inst (.*);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (line_drive_p === 1'b1) p_cnt++;
    if (line_drive_n === 1'b1) n_cnt++;
    // The run needs about 390 cycles
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] p, input logic [7:0] n);
    pos_bits = p;
    neg_bits = n;
    send = 1'b1;
    @(negedge clk_sys) send = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk_sys);
    check("frame done", {3'h0, busy}, 4'h0);
    repeat (20) @(negedge clk_sys);
  endtask
  // Line silent since reset: quiet until the alarm count, then all forced high
  task automatic los_test();
    repeat (LOS_CYCLES - 8) @(negedge clk_sys);
    check("rx before loss", rx_bus, 4'h0);
    repeat (20) @(negedge clk_sys);
    check("rx on loss", rx_bus, 4'hf);
  endtask
  // Positive, negative, then both senses high, which gives no indication
  task automatic rx_test();
    for (int k = 0; k < 3; k++) begin
      line_sense_p = (k != 1);
      line_sense_n = (k != 0);
      repeat (6) @(negedge clk_sys);
      check("rx mark", rx_bus, {k == 0, k == 1, 2'h2});
      line_sense_p = 1'b0;
      line_sense_n = 1'b0;
      repeat (12) @(negedge clk_sys);
      check("rx idle", rx_bus, 4'h0);
    end
  endtask
  // Bench rate then the top rate; fifth word has both requests high
  task automatic tx_test();
    for (int r = 0; r < 2; r++) begin
      fast = (r == 1);
      p_cnt = 0;
      n_cnt = 0;
      frame(8'h19, 8'h12);
      check("pos cycles", p_cnt[3:0], 4'(2 * TX_PULSE_CYCLES));
      check("neg cycles", n_cnt[3:0], 4'(TX_PULSE_CYCLES));
      check("rate error", {3'h0, tx_rate_error}, 4'h0);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    arst_n = 1'b1;
    los_test();
    rx_test();
    tx_test();
    final_report();
  end
endmodule
`default_nettype wire
